// ===== verilog/flash_ctl_pkg.sv
// constants and types shared by the flash mode and reset control
package flash_ctl_pkg;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int ADDR_ACCESS_NS = 60;
	localparam int SLEEP_EXTRA_NS = 60;
	localparam int SELECT_ACCESS_NS = 60;
	localparam int SLOW_CLK_MHZ = 5;
	localparam int RESET_IDLE_NS = 500;
	localparam int RESET_BUSY_US = 11;
	localparam int SLEEP_CYC =
		(ADDR_ACCESS_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_CYC =
		(SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_CLK_CYC = 1000 / SLOW_CLK_MHZ / CLK_PERIOD_NS;
	localparam int RESET_IDLE_CYC = RESET_IDLE_NS / CLK_PERIOD_NS;
	localparam int RESET_BUSY_CYC = RESET_BUSY_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	// --------------------------------------------------------------
	// command bytes on the low data byte
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_UNLOCK_A = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SECT = 8'h30;
	localparam logic [7:0] CMD_ERASE_CHIP = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h3C;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_AUTOSEL = 8'h90;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYPASS_EXIT = 8'h0F;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_PROTECT = 8'h60;
	localparam logic [7:0] CMD_PW_UNLOCK = 8'h25;
	localparam logic [7:0] CMD_PW_PROGRAM = 8'h38;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {SEQ_IDLE = 2'h0, SEQ_UNLOCK1 = 2'h1,
		SEQ_UNLOCK2 = 2'h3, SEQ_ARG = 2'h2} seq_t;
	typedef enum logic [2:0] {OP_PROGRAM, OP_ERASE, OP_PROTECT,
		OP_PW_UNLOCK, OP_PW_PROGRAM} op_t;
	typedef enum logic [1:0] {MODE_ARRAY, MODE_AUTOSEL, MODE_QUERY} mode_t;
	typedef enum logic [1:0] {SRC_ARRAY, SRC_STATUS, SRC_IDENT,
		SRC_QUERY} src_t;
endpackage : flash_ctl_pkg

// ===== verilog/flash_pins_if.sv
// synchronised pin view passed from the write detector to the controller
`timescale 1ns/1ns
`default_nettype none
interface flash_pins_if #(parameter int ADDR_W = 19);
	logic chipSelN;
	logic outEnN;
	logic writeEnN;
	logic hwResetN;
	logic boost;
	logic writeProtectN;
	logic [ADDR_W-1:0] address;
	logic [ADDR_W-1:0] writeAddr;
	logic [7:0] data;
	logic writeStb;
	logic addrLatch;
	logic clkRise;
	logic clkHigh;
	modport detect (output chipSelN, outEnN, writeEnN, hwResetN, boost,
		writeProtectN, address, writeAddr, data, writeStb, addrLatch,
		clkRise, clkHigh);
	modport ctl (input chipSelN, outEnN, writeEnN, hwResetN, boost,
		writeProtectN, address, writeAddr, data, writeStb, addrLatch,
		clkRise, clkHigh);
endinterface : flash_pins_if
`default_nettype wire

// ===== verilog/bank_decode.sv
// maps the two top address bits to a bank for the ordering option
`timescale 1ns/1ns
`default_nettype none
module bank_decode
(
	input wire logic [1:0] bankSelectBits,
	input wire logic orderOption,
	output logic bank,
	output logic smallBank
);
	// bank and size decode
	always_comb
	begin
		bank = orderOption ? (&bankSelectBits) : (|bankSelectBits);
		smallBank = (bank == orderOption);
	end
endmodule : bank_decode
`default_nettype wire

// ===== verilog/write_cycle_detect.sv
// pin synchronisers and asynchronous / synchronous write cycle detection
`timescale 1ns/1ns
`default_nettype none
module write_cycle_detect
	import flash_ctl_pkg::*;
#(
	parameter int ADDR_W = 19
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chipSelN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic addressValidN,
	input wire logic flashClk,
	input wire logic hwResetN,
	input wire logic programBoostInput,
	input wire logic writeProtectN,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [7:0] lowDataByte,
	flash_pins_if.detect pins
);
	localparam int W = ADDR_W + 16;
	// idle pin levels, so no false edge follows reset
	localparam logic [W-1:0] SYNC_IDLE = {8'hF5, {(ADDR_W + 8){1'b0}}};
	logic [W-1:0] sync1_r;
	logic [W-1:0] sync2_r;
	logic weDly_r;
	logic clkDly_r;
	logic [1:0] settle_r;
	logic latchValid_r;
	logic [ADDR_W-1:0] latchAddr_r;
	logic armed;
	logic avS;
	logic clkS;

	// --------------------------------------------------------------
	// two-stage synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sync1_r <= SYNC_IDLE;
			sync2_r <= SYNC_IDLE;
		end
		else
		begin
			sync1_r <= {chipSelN, outEnN, writeEnN, addressValidN, flashClk,
				hwResetN, programBoostInput, writeProtectN, address,
				lowDataByte};
			sync2_r <= sync1_r;
		end
	end

	assign {pins.chipSelN, pins.outEnN, pins.writeEnN, avS, clkS,
		pins.hwResetN, pins.boost, pins.writeProtectN, pins.address,
		pins.data} = sync2_r;

	// edge history and settle guard after reset
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			weDly_r <= 1'b1;
			clkDly_r <= 1'b0;
			settle_r <= 2'h0;
		end
		else
		begin
			weDly_r <= pins.writeEnN;
			clkDly_r <= clkS;
			if (!armed)
				settle_r <= settle_r + 2'h1;
		end
	end

	assign armed = (settle_r == 2'h3);
	assign pins.clkRise = armed & clkS & !clkDly_r;
	assign pins.clkHigh = clkS;
	// address latched by the clock while address-valid is low
	assign pins.addrLatch = pins.clkRise & !avS & !pins.chipSelN
		& pins.outEnN;
	// data taken on the rising write-enable with output-enable high
	assign pins.writeStb = armed & pins.writeEnN & !weDly_r
		& !pins.chipSelN & pins.outEnN;

	// synchronous write address capture
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			latchValid_r <= 1'b0;
			latchAddr_r <= '0;
		end
		else if (pins.chipSelN)
			latchValid_r <= 1'b0;
		else if (pins.addrLatch)
		begin
			latchValid_r <= 1'b1;
			latchAddr_r <= pins.address;
		end
	end

	assign pins.writeAddr = latchValid_r ? latchAddr_r : pins.address;
endmodule : write_cycle_detect
`default_nettype wire

// ===== verilog/flash_bank_mode_ctl.sv
// bank, command, sleep, standby and reset control of a two-bank flash
// Behaviour
// - option 00: top bits 00 are bank 0, 01 or 1X bank 1.
// - option 01: top bits 0X or 10 are bank 0, 11 bank 1.
// - option 00 makes bank 0 small; option 01 makes bank 1 small.
// - reads of the idle bank are served while the other bank works.
// - erase suspend allows reads and programs outside the suspended sector.
// - concurrency covers array reads, not query mode or password program.
// - protect and password unlock: big bank array, small bank status.
// - unlock bypass programs in two write cycles instead of four.
// - erase targets one sector, several sectors or the whole array.
// - identification mode returns codes on the low data byte.
// - synchronous writes latch the address with clock and address-valid.
// - boost input at high voltage enters unlock bypass automatically.
// - write-protected sectors block program and sector erase; chip erase launches without the check.
// - async sleep after stable address for access time plus 60 ns.
// - sync sleep on long first clock level or clock below 5 MHz.
// - select and reset high give standby; reads wait select access time.
// - deselecting never aborts a running program or erase.
// - reset low returns to read state and tristates the data outputs.
// - reset during an operation holds ready/busy low up to 11 us.
// - idle banks readable 500 ns after reset; busy banks after 11 us.
// - after reset the device reads the array without any command.
// - write protect guards the two outermost sectors of a boot block.
`timescale 1ns/1ns
`default_nettype none
module flash_bank_mode_ctl
	import flash_ctl_pkg::*;
#(
	parameter int ADDR_W = 19,
	parameter int SECT_W = 6
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chipSelN,
	input wire logic outEnN,
	input wire logic writeEnN,
	input wire logic addressValidN,
	input wire logic flashClk,
	input wire logic hwResetN,
	input wire logic programBoostInput,
	input wire logic writeProtectN,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [7:0] lowDataByte,
	input wire logic orderOption,
	input wire logic syncMode,
	input wire logic topBoot,
	input wire logic [1:0] coreDone,
	output logic readyBusyN,
	output logic dataOutEnN,
	output src_t dataSource,
	output logic readBank,
	output logic readSmallBank,
	output logic autoSleepMode,
	output logic standby,
	output logic bypassMode,
	output mode_t readMode,
	output logic eraseSuspended,
	output logic coreStart,
	output op_t coreKind,
	output logic [1:0] coreBanks,
	output logic [SECT_W-1:0] coreSector,
	output logic coreChip
);
	if (ADDR_W < SECT_W || SECT_W < 2 || RESET_BUSY_CYC >= 2 ** CNT_W)
		$error("flash_bank_mode_ctl: unsupported widths");

	flash_pins_if #(.ADDR_W(ADDR_W)) pins ();
	seq_t seq_r;
	op_t opKind_r;
	logic [1:0] busy_r;
	logic suspended_r;
	logic suspBank_r;
	logic suspProg_r;
	logic [SECT_W-1:0] suspSector_r;
	logic [SECT_W-1:0] eraseSector_r;
	logic [CNT_W-1:0] recCnt_r [2];
	logic [1:0] wasBusy_r;
	logic hwRstDly_r;
	logic [CNT_W-1:0] selCnt_r;
	logic [CNT_W-1:0] sleepCnt_r;
	logic [CNT_W-1:0] highCnt_r;
	logic [ADDR_W-1:0] addrPrev_r;
	logic rdBank, rdSmall, wrBank, wrSmall;
	logic wrStb, protectHit, progOk, eraseOk, reading, rstHold;
	logic launch, launchChip;
	logic [1:0] launchMask;
	op_t launchOp;
	src_t srcNxt;
	logic [SECT_W-1:0] wrSector, rdSector;

	// --------------------------------------------------------------
	// pin capture and bank decode
	// --------------------------------------------------------------
	write_cycle_detect #(.ADDR_W(ADDR_W)) u_detect (
		.clk(clk), .reset_n(reset_n), .chipSelN(chipSelN),
		.outEnN(outEnN), .writeEnN(writeEnN),
		.addressValidN(addressValidN), .flashClk(flashClk),
		.hwResetN(hwResetN), .programBoostInput(programBoostInput),
		.writeProtectN(writeProtectN), .address(address),
		.lowDataByte(lowDataByte), .pins(pins.detect));
	bank_decode u_readBank (.bankSelectBits(pins.address[ADDR_W-1 -: 2]),
		.orderOption(orderOption), .bank(rdBank), .smallBank(rdSmall));
	bank_decode u_writeBank (.bankSelectBits(pins.writeAddr[ADDR_W-1 -: 2]),
		.orderOption(orderOption), .bank(wrBank), .smallBank(wrSmall));

	assign rdSector = pins.address[ADDR_W-1 -: SECT_W];
	assign wrSector = pins.writeAddr[ADDR_W-1 -: SECT_W];
	assign wrStb = pins.writeStb & pins.hwResetN;
	// the two outermost sectors of the chosen boot end
	assign protectHit = !pins.writeProtectN && (topBoot
		? (wrSector[SECT_W-1:1] == '1)
		: (wrSector[SECT_W-1:1] == '0));
	assign progOk = !protectHit && (!busy_r[wrBank] || (suspended_r
		&& !suspProg_r && suspBank_r == wrBank
		&& wrSector != suspSector_r));
	assign eraseOk = !protectHit && (!busy_r[wrBank]
		|| (opKind_r == OP_ERASE && !suspended_r));

	// --------------------------------------------------------------
	// command decode into operation launches
	// --------------------------------------------------------------
	always_comb
	begin
		launch = 1'b0;
		launchChip = 1'b0;
		launchOp = OP_PROGRAM;
		launchMask = 2'b01 << wrBank;
		if (wrStb && seq_r == SEQ_ARG)
			launch = progOk;
		else if (wrStb && seq_r == SEQ_UNLOCK2)
		begin
			case (pins.data)
				CMD_ERASE_SECT:
				begin
					launch = eraseOk;
					launchOp = OP_ERASE;
				end
				CMD_ERASE_CHIP:
				begin
					launch = (busy_r == 2'b00);
					launchOp = OP_ERASE;
					launchChip = 1'b1;
					launchMask = 2'b11;
				end
				CMD_PROTECT, CMD_PW_UNLOCK:
				begin
					launch = (busy_r == 2'b00);
					launchOp = (pins.data == CMD_PROTECT) ? OP_PROTECT
						: OP_PW_UNLOCK;
					launchMask = 2'b01 << orderOption;
				end
				CMD_PW_PROGRAM:
				begin
					launch = (busy_r == 2'b00);
					launchOp = OP_PW_PROGRAM;
					launchMask = 2'b11;
				end
				default:
					launch = 1'b0;
			endcase
		end
	end

	// command sequencer and read mode
	always_ff @(posedge clk)
	begin
		if (!reset_n || !pins.hwResetN)
		begin
			seq_r <= SEQ_IDLE;
			readMode <= MODE_ARRAY;
			bypassMode <= 1'b0;
		end
		else
		begin
			if (pins.boost)
				bypassMode <= 1'b1;
			if (wrStb && pins.data == CMD_RESET)
			begin
				seq_r <= SEQ_IDLE;
				readMode <= MODE_ARRAY;
			end
			else if (wrStb)
			begin
				case (seq_r)
					SEQ_IDLE:
						if (pins.data == CMD_UNLOCK_A)
							seq_r <= SEQ_UNLOCK1;
						else if (bypassMode && pins.data == CMD_PROGRAM)
							seq_r <= SEQ_ARG;
						else if (pins.data == CMD_BYPASS_EXIT && !pins.boost)
							bypassMode <= 1'b0;
					SEQ_UNLOCK1:
						seq_r <= (pins.data == CMD_UNLOCK_B) ? SEQ_UNLOCK2
							: SEQ_IDLE;
					SEQ_UNLOCK2:
					begin
						seq_r <= (pins.data == CMD_PROGRAM) ? SEQ_ARG : SEQ_IDLE;
						if (pins.data == CMD_AUTOSEL)
							readMode <= MODE_AUTOSEL;
						if (pins.data == CMD_QUERY)
							readMode <= MODE_QUERY;
						if (pins.data == CMD_BYPASS)
							bypassMode <= 1'b1;
					end
					SEQ_ARG:
						seq_r <= SEQ_IDLE;
					default:
						seq_r <= SEQ_IDLE;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// per-bank busy, suspend and core handoff
	// --------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n || !pins.hwResetN)
		begin
			busy_r <= 2'b00;
			opKind_r <= OP_PROGRAM;
			eraseSector_r <= '0;
		end
		else
		begin
			// a deselect never touches busy; only the core or a hardware reset ends an operation
			busy_r <= (busy_r & ~(coreDone & ~({2{suspProg_r}})))
				| (launch ? launchMask : 2'b00);
			if (launch && !suspended_r)
				opKind_r <= launchOp;
			if (launch && launchOp == OP_ERASE)
				eraseSector_r <= wrSector;
		end
	end

	// erase suspend and program inside a suspended bank
	always_ff @(posedge clk)
	begin
		if (!reset_n || !pins.hwResetN)
		begin
			suspended_r <= 1'b0;
			suspBank_r <= 1'b0;
			suspProg_r <= 1'b0;
			suspSector_r <= '0;
		end
		else
		begin
			if (wrStb && seq_r == SEQ_IDLE && pins.data == CMD_SUSPEND
				&& opKind_r == OP_ERASE && busy_r != 2'b00)
			begin
				suspended_r <= 1'b1;
				suspBank_r <= busy_r[1] & !busy_r[0];
				suspSector_r <= eraseSector_r;
			end
			else if (wrStb && seq_r == SEQ_IDLE && pins.data == CMD_RESUME
				&& !suspProg_r)
				suspended_r <= 1'b0;
			if (launch && suspended_r)
				suspProg_r <= 1'b1;
			else if (coreDone[suspBank_r])
				suspProg_r <= 1'b0;
		end
	end

	// core start pulse with target
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			coreStart <= 1'b0;
			coreKind <= OP_PROGRAM;
			coreBanks <= 2'b00;
			coreSector <= '0;
			coreChip <= 1'b0;
		end
		else
		begin
			coreStart <= launch;
			if (launch)
			begin
				coreKind <= launchOp;
				coreBanks <= launchMask;
				coreSector <= wrSector;
				coreChip <= launchChip;
			end
		end
	end

	assign eraseSuspended = suspended_r;

	// --------------------------------------------------------------
	// hardware reset recovery per bank
	// --------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			hwRstDly_r <= 1'b1;
			wasBusy_r <= 2'b00;
			recCnt_r[0] <= '0;
			recCnt_r[1] <= '0;
		end
		else
		begin
			hwRstDly_r <= pins.hwResetN;
			for (int b = 0; b < 2; b++)
			begin
				if (hwRstDly_r && !pins.hwResetN)
				begin
					wasBusy_r[b] <= busy_r[b];
					recCnt_r[b] <= busy_r[b] ? CNT_W'(RESET_BUSY_CYC)
						: CNT_W'(RESET_IDLE_CYC);
				end
				else if (recCnt_r[b] != '0)
					recCnt_r[b] <= recCnt_r[b] - 1'b1;
			end
		end
	end

	assign rstHold = (wasBusy_r[0] && recCnt_r[0] != '0)
		|| (wasBusy_r[1] && recCnt_r[1] != '0);

	// ready/busy
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			readyBusyN <= 1'b1;
		else
			readyBusyN <= !(rstHold || suspProg_r || (!suspended_r
				&& busy_r != 2'b00));
	end

	// --------------------------------------------------------------
	// standby, read path and output enable
	// --------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			standby <= 1'b0;
			selCnt_r <= '0;
		end
		else
		begin
			standby <= pins.chipSelN & pins.hwResetN;
			if (pins.chipSelN)
				selCnt_r <= CNT_W'(SELECT_CYC);
			else if (selCnt_r != '0)
				selCnt_r <= selCnt_r - 1'b1;
		end
	end

	assign reading = !pins.chipSelN && !pins.outEnN && pins.writeEnN
		&& pins.hwResetN && selCnt_r == '0;

	// data source for the addressed bank
	always_comb
	begin
		srcNxt = SRC_ARRAY;
		if (readMode == MODE_AUTOSEL)
			srcNxt = SRC_IDENT;
		else if (readMode == MODE_QUERY)
			srcNxt = (busy_r != 2'b00) ? SRC_STATUS : SRC_QUERY;
		else if (recCnt_r[rdBank] != '0)
			srcNxt = SRC_STATUS;
		else if (busy_r[rdBank] && !(suspended_r && !suspProg_r
			&& suspBank_r == rdBank && rdSector != suspSector_r))
			srcNxt = SRC_STATUS;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			dataOutEnN <= 1'b1;
			dataSource <= SRC_ARRAY;
			readBank <= 1'b0;
			readSmallBank <= 1'b0;
		end
		else
		begin
			dataOutEnN <= !reading;
			dataSource <= srcNxt;
			readBank <= rdBank;
			readSmallBank <= rdSmall;
		end
	end

	// --------------------------------------------------------------
	// automatic sleep
	// --------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			autoSleepMode <= 1'b0;
			sleepCnt_r <= '0;
			highCnt_r <= '0;
			addrPrev_r <= '0;
		end
		else
		begin
			addrPrev_r <= pins.address;
			if (!syncMode)
			begin
				highCnt_r <= '0;
				if (pins.address != addrPrev_r)
				begin
					sleepCnt_r <= '0;
					autoSleepMode <= 1'b0;
				end
				else if (sleepCnt_r < CNT_W'(SLEEP_CYC))
					sleepCnt_r <= sleepCnt_r + 1'b1;
				else
					autoSleepMode <= 1'b1;
			end
			else if (pins.addrLatch)
			begin
				sleepCnt_r <= '0;
				highCnt_r <= '0;
				autoSleepMode <= 1'b0;
			end
			else
			begin
				sleepCnt_r <= pins.clkRise ? '0 : sleepCnt_r
					+ CNT_W'(sleepCnt_r != '1);
				highCnt_r <= pins.clkHigh ? highCnt_r
					+ CNT_W'(highCnt_r != '1) : '0;
				if (sleepCnt_r > CNT_W'(SLOW_CLK_CYC)
					|| highCnt_r > CNT_W'(ACCESS_CYC))
					autoSleepMode <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	chk_bank_opt_zero: assert property (!orderOption
		|=> readBank == $past(|pins.address[ADDR_W-1 -: 2]))
		else $error("bank decode wrong for option 00");
	chk_bank_opt_one: assert property (orderOption
		|=> readBank == $past(&pins.address[ADDR_W-1 -: 2]))
		else $error("bank decode wrong for option 01");
	chk_small_bank: assert property (1'b1 |=> readSmallBank
		== (readBank == $past(orderOption)))
		else $error("small bank assignment wrong");
	chk_reset_tristate: assert property (!pins.hwResetN
		|=> dataOutEnN && readMode == MODE_ARRAY)
		else $error("outputs driven during reset");
	chk_busy_pin: assert property (busy_r != 2'b00 && !suspended_r
		|=> !readyBusyN)
		else $error("ready/busy high while busy");
	chk_boost_bypass: assert property (pins.boost && pins.hwResetN
		|=> bypassMode)
		else $error("boost did not enter bypass");
	chk_busy_reset: assert property (hwRstDly_r && !pins.hwResetN
		&& busy_r != 2'b00 |=> !readyBusyN [*8])
		else $error("ready/busy released too early after reset");
	chk_idle_reset: assert property (hwRstDly_r && !pins.hwResetN
		&& busy_r == 2'b00 |=> recCnt_r[0] == 8'h0A ##10 recCnt_r[0] == 8'h00)
		else $error("idle reset recovery not 500 ns");
	chk_wp_guard: assert property (launch && !launchChip
		&& (launchOp == OP_PROGRAM || launchOp == OP_ERASE) |-> !protectHit)
		else $error("protected sector launched");
	chk_standby_off: assert property (standby |-> ##1 dataOutEnN)
		else $error("outputs driven in standby");
endmodule : flash_bank_mode_ctl
`default_nettype wire

// ===== verif/flash_host_model.sv
// host side pin driver for the flash mode control
`timescale 1ns/1ns
`default_nettype none
module flash_host_model
(
	input wire logic clk,
	output logic chipSelN,
	output logic outEnN,
	output logic writeEnN,
	output logic [18:0] address,
	output logic [7:0] lowDataByte
);
	// pins idle: deselected, no strobes
	initial
	begin
		chipSelN = 1'b1;
		outEnN = 1'b1;
		writeEnN = 1'b1;
		address = 19'h0_0000;
		lowDataByte = 8'h00;
	end
	// one write cycle; spacing covers the two-flop pin synchronisers
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		@(negedge clk);
		address = a;
		lowDataByte = d;
		outEnN = 1'b1;
		chipSelN = 1'b0;
		writeEnN = 1'b0;
		repeat (3) @(negedge clk);
		writeEnN = 1'b1;
		repeat (3) @(negedge clk);
		chipSelN = 1'b1;
		lowDataByte = ~d; // released bus does not keep its value
		@(negedge clk); // launch and busy settle before return
	endtask : wr
	// read levels: select and output enable held until changed
	task automatic drive(input logic cs, input logic oe, input logic [18:0] a);
		@(negedge clk);
		chipSelN = cs;
		outEnN = oe;
		address = a;
	endtask : drive
endmodule : flash_host_model
`default_nettype wire

// ===== verif/tb_flash_bank_mode_ctl.sv
// self-checking bench for the flash mode and reset control
`timescale 1ns/1ns
`default_nettype none
module tb_flash_bank_mode_ctl;
	import flash_ctl_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hwResetN = 1'b1;
	logic writeProtectN = 1'b1;
	logic orderOption = 1'b0;
	logic [1:0] coreDone = 2'h0;
	logic chipSelN, outEnN, writeEnN, readyBusyN, dataOutEnN, readBank;
	logic readSmallBank, standby, bypassMode, coreStart;
	logic boost = 1'b0;
	logic autoSleepMode, eraseSuspended, coreChip;
	logic [1:0] coreBanks;
	logic [5:0] coreSector;
	logic [18:0] address;
	logic [7:0] lowDataByte;
	src_t dataSource;
	mode_t readMode;
	op_t coreKind;
	int nMismatch = 0;
	int samplesChecked = 0;
	int nStart = 0;
	logic expBank;
	// clock and launch counter
	always #25 clk = ~clk;
	always @(posedge clk) if (coreStart === 1'b1) nStart <= nStart + 1;
	flash_host_model u_flash_host_model (.clk(clk), .chipSelN(chipSelN),
		.outEnN(outEnN), .writeEnN(writeEnN), .address(address),
		.lowDataByte(lowDataByte));
	flash_bank_mode_ctl u_flash_bank_mode_ctl (.clk(clk), .reset_n(reset_n),
		.chipSelN(chipSelN), .outEnN(outEnN), .writeEnN(writeEnN),
		.addressValidN(1'b1), .flashClk(1'b0), .hwResetN(hwResetN),
		.programBoostInput(boost), .writeProtectN(writeProtectN),
		.address(address), .lowDataByte(lowDataByte),
		.orderOption(orderOption), .syncMode(1'b0), .topBoot(1'b1),
		.coreDone(coreDone), .readyBusyN(readyBusyN),
		.dataOutEnN(dataOutEnN), .dataSource(dataSource),
		.readBank(readBank), .readSmallBank(readSmallBank),
		.autoSleepMode(autoSleepMode), .standby(standby),
		.bypassMode(bypassMode), .readMode(readMode),
		.eraseSuspended(eraseSuspended), .coreStart(coreStart),
		.coreKind(coreKind), .coreBanks(coreBanks),
		.coreSector(coreSector), .coreChip(coreChip));
	// --------------------------------------------------------------
	// checking and closing
	// --------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// unlock prefix of a standard command
	task automatic cmd(input logic [7:0] c);
		u_flash_host_model.wr(19'h0_0555, CMD_UNLOCK_A);
		u_flash_host_model.wr(19'h0_02AA, CMD_UNLOCK_B);
		u_flash_host_model.wr(19'h0_0555, c);
	endtask : cmd
	// one-cycle completion pulse from the core for bank 0
	task automatic core_done;
		@(negedge clk);
		coreDone = 2'h1;
		@(negedge clk);
		coreDone = 2'h0;
		repeat (2) @(negedge clk);
	endtask : core_done
	// watchdog well past the longest expected run
	initial
	begin
		repeat (6000) @(posedge clk);
		nMismatch++;
		close_out;
	end
	// --------------------------------------------------------------
	// test sequence
	// --------------------------------------------------------------
	initial
	begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		chk(readMode, MODE_ARRAY);
		chk(readyBusyN, 1'b1);
		// bank map and small bank for both ordering options
		for (int k = 0; k < 8; k++)
		begin
			orderOption = k[2];
			expBank = k[2] ? (k[1:0] == 2'd3) : (k[1:0] != 2'd0);
			u_flash_host_model.drive(1'b0, 1'b0, {k[1:0], 17'h0_0000});
			repeat (4) @(negedge clk);
			chk(readBank, expBank);
			chk(readSmallBank, k[2] ? expBank : !expBank);
		end
		orderOption = 1'b0;
		u_flash_host_model.drive(1'b1, 1'b1, 19'h0_0000);
		// standard four-cycle program in the small bank
		cmd(CMD_PROGRAM);
		u_flash_host_model.wr(19'h0_1000, 8'h5A);
		chk(nStart, 1);
		chk(coreKind, OP_PROGRAM);
		chk(readyBusyN, 1'b0);
		// big bank stays readable, busy bank gives status
		u_flash_host_model.drive(1'b0, 1'b0, 19'h4_0000);
		repeat (6) @(negedge clk);
		chk(dataSource, SRC_ARRAY);
		chk(dataOutEnN, 1'b0);
		u_flash_host_model.drive(1'b0, 1'b0, 19'h0_1000);
		repeat (4) @(negedge clk);
		chk(dataSource, SRC_STATUS);
		chk(autoSleepMode, 1'b0);
		// deselect does not abort the running program
		u_flash_host_model.drive(1'b1, 1'b1, 19'h0_1000);
		repeat (4) @(negedge clk);
		chk(standby, 1'b1);
		chk(dataOutEnN, 1'b1);
		chk(readyBusyN, 1'b0);
		// hardware reset during program: long busy recovery
		u_flash_host_model.drive(1'b0, 1'b0, 19'h4_0000);
		hwResetN = 1'b0;
		repeat (5) @(negedge clk);
		chk(dataOutEnN, 1'b1);
		hwResetN = 1'b1;
		repeat (150) @(negedge clk);
		chk(readyBusyN, 1'b0);
		chk(autoSleepMode, 1'b1);
		repeat (90) @(negedge clk);
		chk(readyBusyN, 1'b1);
		chk(readMode, MODE_ARRAY);
		chk(dataSource, SRC_ARRAY);
		u_flash_host_model.drive(1'b1, 1'b1, 19'h0_0000);
		// unlock bypass: two-cycle program, then core completion
		cmd(CMD_BYPASS);
		chk(bypassMode, 1'b1);
		u_flash_host_model.wr(19'h0_1000, CMD_PROGRAM);
		u_flash_host_model.wr(19'h0_1000, 8'h5A);
		chk(nStart, 2);
		core_done;
		chk(readyBusyN, 1'b1);
		// write-protected outermost top sector is refused
		writeProtectN = 1'b0;
		u_flash_host_model.wr(19'h7_F000, CMD_PROGRAM);
		u_flash_host_model.wr(19'h7_F000, 8'h11);
		chk(nStart, 2);
		writeProtectN = 1'b1;
		u_flash_host_model.wr(19'h0_0000, CMD_BYPASS_EXIT);
		chk(bypassMode, 1'b0);
		// boost input enters bypass by itself
		boost = 1'b1;
		repeat (4) @(negedge clk);
		chk(bypassMode, 1'b1);
		boost = 1'b0;
		// sector erase, suspend, read beside the sector, resume
		cmd(CMD_ERASE_SECT);
		chk(coreKind, OP_ERASE);
		chk(coreBanks, 2'b01);
		chk(coreSector, 6'h00);
		chk(coreChip, 1'b0);
		u_flash_host_model.wr(19'h0_0000, CMD_SUSPEND);
		chk(eraseSuspended, 1'b1);
		u_flash_host_model.drive(1'b0, 1'b0, 19'h1_0000);
		repeat (4) @(negedge clk);
		chk(dataSource, SRC_ARRAY);
		u_flash_host_model.wr(19'h0_0000, CMD_RESUME);
		chk(eraseSuspended, 1'b0);
		core_done;
		chk(readyBusyN, 1'b1);
		// identification mode reads codes, reset command leaves it
		cmd(CMD_AUTOSEL);
		chk(readMode, MODE_AUTOSEL);
		u_flash_host_model.drive(1'b0, 1'b0, 19'h4_0000);
		repeat (4) @(negedge clk);
		chk(dataSource, SRC_IDENT);
		u_flash_host_model.drive(1'b1, 1'b1, 19'h0_0000);
		u_flash_host_model.wr(19'h0_0000, CMD_RESET);
		chk(readMode, MODE_ARRAY);
		// query mode, then an idle hardware reset leaves it
		cmd(CMD_QUERY);
		chk(readMode, MODE_QUERY);
		u_flash_host_model.drive(1'b0, 1'b0, 19'h4_0000);
		repeat (4) @(negedge clk);
		chk(dataSource, SRC_QUERY);
		hwResetN = 1'b0;
		repeat (4) @(negedge clk);
		hwResetN = 1'b1;
		repeat (20) @(negedge clk);
		chk(readMode, MODE_ARRAY);
		chk(readyBusyN, 1'b1);
		close_out;
	end
endmodule : tb_flash_bank_mode_ctl
`default_nettype wire
